// File: hdl/psr_pin_state_retention.sv
// Purpose: pin state control across reset, software standby, deep standby
// Assumes: power-mode controller drives powerMode and deepCancel in clk domain
// Notes:   pad outputs are registered; they follow the state one cycle later
//
// Function
// - reset: pull-ups on mode/jtag, tdo drives
// - software standby: outputs keep previous value
// - software standby: inputs go high-impedance
// - deep standby freezes software standby pin state
// - cancel without hold: hi-z, tdo drives
// - cancel with hold: freeze until bit cleared
// - software-standby wake pins keep input enabled
// - deep-standby wake pins keep input enabled
// - software standby: usb data pins keep input while inputs
// - software standby: analog, rtc, clock outputs keep driving live

`timescale 1ns/1ps

module psr_pin_state_retention #(
  parameter int unsigned       NPINS     = 16,          // general pins
  parameter logic [NPINS-1:0]  SW_WAKE_M = 16'h00ff,    // sw-standby wake capable
  parameter logic [NPINS-1:0]  DEEP_WK_M = 16'h0f0f,    // deep-standby wake capable
  parameter logic [NPINS-1:0]  USB_DAT_M = 16'h3000     // usb d+ / d- positions
) (
  input  wire logic                       clk,          // 200 MHz clock
  input  wire logic                       rst_b,        // sync reset, low active
  input  wire logic [1:0]                 powerMode,    // requested power mode
  input  wire logic                       deepCancel,   // deep standby cancel pulse
  input  wire logic [NPINS-1:0]           funcOut,      // functional output value
  input  wire logic [NPINS-1:0]           funcOe,       // functional output enable
  input  wire logic [NPINS-1:0]           funcIe,       // functional input enable
  input  wire logic [NPINS-1:0]           swWakeSel,    // chosen sw-standby wake
  input  wire logic [NPINS-1:0]           deepWakeSel,  // chosen deep-standby wake
  input  wire logic [NPINS-1:0]           liveDrive,    // rtc/clock/analog selected
  input  wire logic                       jtagTdo,      // tdo from debug logic
  input  wire logic [psr_pkg::REG_AW-1:0] regAddr,      // register address
  input  wire logic [psr_pkg::REG_DW-1:0] regWrData,    // register write data
  input  wire logic                       regWr,        // write strobe
  input  wire logic                       regRd,        // read strobe
  output logic      [psr_pkg::REG_DW-1:0] regRdData,    // read data, next cycle
  output logic      [NPINS-1:0]           padOut,       // pad output value
  output logic      [NPINS-1:0]           padOe,        // pad output enable
  output logic      [NPINS-1:0]           padIe,        // pad input enable
  output logic                            modePullUp,   // mode_select_pin pull-up
  output logic      [2:0]                 jtagPullUp,   // tck, tms, tdi pull-ups
  output logic                            tdoOut,       // tdo pad value
  output logic                            tdoOe,        // tdo pad output enable
  output logic                            ioRetentionHold // hold bit, mirrored
);

  // ==========================================================================
  // declarations
  // ==========================================================================
  psr_pkg::psr_state_t         state_q;                 // controller state
  psr_pkg::psr_state_t         state_d;                 // next state
  logic                        keep_q;                  // io_retention_hold
  logic [NPINS-1:0]            keepOut_q;               // latched output value
  logic [NPINS-1:0]            keepOe_q;                // latched direction
  logic                        keepTdo_q;               // latched tdo value
  logic [NPINS-1:0]            padOut_q;                // pad value register
  logic [NPINS-1:0]            padOe_q;                 // pad enable register
  logic [NPINS-1:0]            padIe_q;                 // pad input register
  logic [NPINS-1:0]            padOut_d;                // pad value next
  logic [NPINS-1:0]            padOe_d;                 // pad enable next
  logic [NPINS-1:0]            padIe_d;                 // pad input next
  logic                        modePu_q;                // mode pull-up register
  logic                        modePu_d;                // mode pull-up next
  logic [2:0]                  jtagPu_q;                // jtag pull-up register
  logic [2:0]                  jtagPu_d;                // jtag pull-up next
  logic                        tdoOut_q;                // tdo value register
  logic                        tdoOut_d;                // tdo value next
  logic                        tdoOe_q;                 // tdo enable register
  logic                        tdoOe_d;                 // tdo enable next
  logic [psr_pkg::REG_DW-1:0]  rdData_q;                // read data register
  logic [psr_pkg::REG_DW-1:0]  rdData_d;                // read data next
  logic                        ctrlWr;                  // write hits control
  logic                        releaseWr;               // release command write
  logic [NPINS-1:0]            wakeEnSw;                // sw-standby input enables
  logic [NPINS-1:0]            wakeEnDeep;              // deep input enables

  // ==========================================================================
  // register port decode
  // ==========================================================================
  // only the control offset takes writes; other offsets are ignored
  assign ctrlWr    = regWr && (regAddr == psr_pkg::CTRL_OFS);
  assign releaseWr = ctrlWr && regWrData[psr_pkg::CTRL_REL_BIT];

  // retention hold bit, only software writes it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      keep_q <= psr_pkg::KEEP_RST;
    end else if (ctrlWr) begin
      keep_q <= regWrData[psr_pkg::CTRL_KEEP_BIT];
    end
  end

  // read mux, zero on unmapped address or no strobe
  always_comb begin
    rdData_d = '0;
    if (regRd) begin
      case (regAddr)
        psr_pkg::CTRL_OFS: begin
          rdData_d[psr_pkg::CTRL_KEEP_BIT] = keep_q;  // release reads zero
        end
        psr_pkg::STAT_OFS: begin
          rdData_d[psr_pkg::STAT_ST_LSB +: psr_pkg::STAT_ST_W] = state_q;
        end
        default: begin
          rdData_d = '0;
        end
      endcase
    end
  end

  // read data stands one cycle only
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdData_q <= '0;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  // ==========================================================================
  // mode sequencing
  // ==========================================================================
  always_comb begin
    state_d = state_q;
    case (state_q)
      psr_pkg::ST_NORMAL: begin
        if (powerMode == psr_pkg::MODE_SW || powerMode == psr_pkg::MODE_DEEP) begin
          state_d = psr_pkg::ST_SWSTBY;                 // deep passes via sw standby
        end
      end
      psr_pkg::ST_SWSTBY: begin
        if (powerMode == psr_pkg::MODE_DEEP) begin
          state_d = psr_pkg::ST_DEEP;
        end else if (powerMode != psr_pkg::MODE_SW) begin
          state_d = psr_pkg::ST_NORMAL;
        end
      end
      psr_pkg::ST_DEEP: begin
        if (deepCancel) begin
          state_d = keep_q ? psr_pkg::ST_POSTHOLD : psr_pkg::ST_POSTHIZ;
        end
      end
      psr_pkg::ST_POSTHOLD: begin
        if (!keep_q) begin
          state_d = psr_pkg::ST_NORMAL;
        end
      end
      psr_pkg::ST_POSTHIZ: begin
        if (releaseWr) begin
          state_d = psr_pkg::ST_NORMAL;                 // software reconfigured ports
        end
      end
      default: begin
        // illegal code recovers to normal operation
        state_d = psr_pkg::ST_NORMAL;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= psr_pkg::ST_NORMAL;
    end else begin
      state_q <= state_d;
    end
  end

  // latch pin value and direction on standby entry
  // only the normal-to-standby edge loads it, so deep entry keeps it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      keepOut_q <= '0;
      keepOe_q  <= '0;
      keepTdo_q <= 1'b0;
    end else if (state_q == psr_pkg::ST_NORMAL && state_d == psr_pkg::ST_SWSTBY) begin
      keepOut_q <= funcOut;
      keepOe_q  <= funcOe;
      keepTdo_q <= jtagTdo;
    end
  end

  // ==========================================================================
  // pad control
  // ==========================================================================
  // inputs kept alive in standby: wake sources, plus usb data inputs in software standby only
  assign wakeEnSw   = (swWakeSel & SW_WAKE_M) | (funcIe & USB_DAT_M);
  assign wakeEnDeep = deepWakeSel & DEEP_WK_M;

  // every pad register holds its value unless the state says otherwise
  always_comb begin
    padOut_d = padOut_q;
    padOe_d  = padOe_q;
    padIe_d  = padIe_q;
    modePu_d = modePu_q;
    jtagPu_d = jtagPu_q;
    tdoOut_d = tdoOut_q;
    tdoOe_d  = tdoOe_q;
    case (state_q)
      psr_pkg::ST_NORMAL: begin                          // functional pass-through
        padOut_d = funcOut;
        padOe_d  = funcOe;
        padIe_d  = funcIe;
        modePu_d = psr_pkg::MODE_PU_RST;
        jtagPu_d = psr_pkg::JTAG_PU_RST;
        tdoOut_d = jtagTdo;
        tdoOe_d  = psr_pkg::TDO_OE_RST;
      end
      psr_pkg::ST_SWSTBY: begin                          // keep outputs, float inputs
        padOut_d = (keepOut_q & ~liveDrive) | (funcOut & liveDrive);
        padOe_d  = (keepOe_q & ~liveDrive) | (funcOe & liveDrive);
        padIe_d  = wakeEnSw;
        modePu_d = 1'b0;
        jtagPu_d = '0;
        tdoOut_d = keepTdo_q;
        tdoOe_d  = 1'b1;
      end
      psr_pkg::ST_DEEP: begin                            // drive state frozen
        padIe_d = wakeEnDeep;
      end
      psr_pkg::ST_POSTHOLD: begin                        // everything frozen
        padIe_d = padIe_q;
      end
      psr_pkg::ST_POSTHIZ: begin                         // startup hi-z
        padOut_d = '0;
        padOe_d  = '0;
        padIe_d  = '0;
        modePu_d = 1'b0;
        jtagPu_d = '0;
        tdoOut_d = jtagTdo;
        tdoOe_d  = 1'b1;
      end
      default: begin
        padOe_d = '0;
        padIe_d = '0;
      end
    endcase
  end

  // pad registers; reset values give the reset pin states
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      padOut_q <= '0;
      padOe_q  <= '0;
      padIe_q  <= '0;
      modePu_q <= psr_pkg::MODE_PU_RST;
      jtagPu_q <= psr_pkg::JTAG_PU_RST;
      tdoOut_q <= 1'b0;
      tdoOe_q  <= psr_pkg::TDO_OE_RST;
    end else begin
      padOut_q <= padOut_d;
      padOe_q  <= padOe_d;
      padIe_q  <= padIe_d;
      modePu_q <= modePu_d;
      jtagPu_q <= jtagPu_d;
      tdoOut_q <= tdoOut_d;
      tdoOe_q  <= tdoOe_d;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  // every output below is a flop, so pads never glitch on mode changes
  assign regRdData       = rdData_q;
  assign padOut          = padOut_q;
  assign padOe           = padOe_q;
  assign padIe           = padIe_q;
  assign modePullUp      = modePu_q;
  assign jtagPullUp      = jtagPu_q;
  assign tdoOut          = tdoOut_q;
  assign tdoOe           = tdoOe_q;
  assign ioRetentionHold = keep_q;

  // ==========================================================================
  // assertions
  // ==========================================================================
  // each property samples the flops one edge after the state that set them
  a_reset_pull_ups: assert property (@(posedge clk) !rst_b |=>
      (modePu_q && jtagPu_q == 3'h7 && tdoOe_q && padOe_q == '0 && padIe_q == '0))
    else $error("reset pin state wrong");

  a_entry_latch: assert property (@(posedge clk) disable iff (!rst_b)
      (state_q == psr_pkg::ST_NORMAL && state_d == psr_pkg::ST_SWSTBY)
      |=> (keepOut_q == $past(funcOut) && keepOe_q == $past(funcOe)))
    else $error("standby entry latch missed");

  a_sw_outputs_kept: assert property (@(posedge clk) disable iff (!rst_b)
      state_q == psr_pkg::ST_SWSTBY
      |=> (((padOe_q ^ $past(keepOe_q)) | (padOut_q ^ $past(keepOut_q)))
           & ~$past(liveDrive)) == '0)
    else $error("standby output not retained");

  a_sw_inputs_float: assert property (@(posedge clk) disable iff (!rst_b)
      state_q == psr_pkg::ST_SWSTBY
      |=> ((padIe_q & ~$past(wakeEnSw)) == '0 && !modePu_q && jtagPu_q == '0))
    else $error("standby input not floated");

  a_deep_frozen: assert property (@(posedge clk) disable iff (!rst_b)
      state_q == psr_pkg::ST_DEEP
      |=> (padOut_q == $past(padOut_q) && padOe_q == $past(padOe_q)
           && tdoOe_q == $past(tdoOe_q)))
    else $error("deep standby pin state moved");

  a_cancel_hiz: assert property (@(posedge clk) disable iff (!rst_b)
      (state_q == psr_pkg::ST_DEEP && deepCancel && !keep_q)
      |=> ##1 (padOe_q == '0 && tdoOe_q && tdoOut_q == $past(jtagTdo)))
    else $error("post-cancel hi-z wrong");

  // a hold clear written in this cycle only counts one edge later, so the
  // branch looks at the hold value that the state machine really used
  a_hold_until_clear: assert property (@(posedge clk) disable iff (!rst_b)
      (state_q == psr_pkg::ST_POSTHOLD)
      |=> ($past(keep_q) ? (state_q == psr_pkg::ST_POSTHOLD && $stable(padOe_q))
                         : state_q == psr_pkg::ST_NORMAL))
    else $error("retention hold not honoured");

  a_sw_wake_input: assert property (@(posedge clk) disable iff (!rst_b)
      state_q == psr_pkg::ST_SWSTBY
      |=> ((~padIe_q & $past(swWakeSel) & SW_WAKE_M) == '0))
    else $error("sw wake input disabled");

  a_deep_wake_input: assert property (@(posedge clk) disable iff (!rst_b)
      state_q == psr_pkg::ST_DEEP |=> padIe_q == ($past(deepWakeSel) & DEEP_WK_M))
    else $error("deep wake input wrong");

  a_usb_input_kept: assert property (@(posedge clk) disable iff (!rst_b)
      state_q == psr_pkg::ST_SWSTBY
      |=> ((~padIe_q & $past(funcIe) & USB_DAT_M) == '0))
    else $error("usb data input disabled");

  a_live_drive: assert property (@(posedge clk) disable iff (!rst_b)
      state_q == psr_pkg::ST_SWSTBY
      |=> (((padOut_q ^ $past(funcOut)) | (padOe_q ^ $past(funcOe)))
           & $past(liveDrive)) == '0)
    else $error("live output not driven");

endmodule

// File: inc/psr_pkg.sv
// Purpose: shared constants and types of the pin state retention controller
// Assumes: one clock, synchronous active-low reset, plain register port
// Notes:   offsets are byte addresses on the register port

package psr_pkg;

  // ==========================================================================
  // register port
  // ==========================================================================
  localparam int unsigned REG_AW = 8;                   // address width
  localparam int unsigned REG_DW = 32;                  // data width
  localparam logic [7:0]  CTRL_OFS = 8'h00;             // deep standby control
  localparam logic [7:0]  STAT_OFS = 8'h04;             // controller status

  // ==========================================================================
  // fields
  // ==========================================================================
  localparam int unsigned CTRL_KEEP_BIT = 0;            // io_retention_hold
  localparam int unsigned CTRL_REL_BIT  = 1;            // release post-deep hi-z
  localparam int unsigned STAT_ST_LSB   = 0;            // state code position
  localparam int unsigned STAT_ST_W     = 3;            // state code width
  localparam logic        KEEP_RST      = 1'b0;         // io_retention_hold reset

  // ==========================================================================
  // power-mode request codes
  // ==========================================================================
  localparam logic [1:0] MODE_RUN  = 2'h0;              // normal operation
  localparam logic [1:0] MODE_SW   = 2'h1;              // software standby
  localparam logic [1:0] MODE_DEEP = 2'h2;              // deep software standby

  // ==========================================================================
  // pad reset values
  // ==========================================================================
  localparam logic       MODE_PU_RST = 1'b1;            // mode_select_pin pulled up
  localparam logic [2:0] JTAG_PU_RST = 3'h7;            // tck, tms, tdi pulled up
  localparam logic       TDO_OE_RST  = 1'b1;            // tdo driven in reset

  // controller states
  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_SWSTBY,
    ST_DEEP,
    ST_POSTHIZ,
    ST_POSTHOLD
  } psr_state_t;

endpackage

// File: tb/psr_board_model.sv
// Purpose: board circuitry seen from the general pins of the controller
// Assumes: pins resolve once per clock; the bench says where the board drives
// Notes:   an undriven pin toggles so a stale level never passes for a real one

`timescale 1ns/1ps

module psr_board_model #(
  parameter int unsigned NPINS = 16                  // general pins
) (
  input  wire logic             clk,                 // bench clock
  input  wire logic [NPINS-1:0] padOut,              // controller pad value
  input  wire logic [NPINS-1:0] padOe,               // controller drives pin
  input  wire logic [NPINS-1:0] extVal,              // board drive value
  input  wire logic [NPINS-1:0] extEn,               // board drives pin
  output logic      [NPINS-1:0] pinLevel,            // resolved pin level
  output int                    clashCount           // both sides driving
);
  // ==========================================================================
  // pin resolution
  // ==========================================================================
  initial pinLevel = '0;
  initial clashCount = 0;

  // resolve each pin; no pull on general pins, so floating pins wander
  always @(posedge clk) begin
    for (int k = 0; k < NPINS; k++) begin
      if (padOe[k] === 1'b1) begin
        pinLevel[k] <= padOut[k];
      end else if (extEn[k]) begin
        pinLevel[k] <= extVal[k];
      end else begin
        pinLevel[k] <= ~pinLevel[k];
      end
    end
    // a released pin must leave room for the board to drive
    if ((padOe & extEn) != '0) begin
      clashCount <= clashCount + 1;
    end
  end
endmodule

// File: tb/psr_pin_state_retention_bench.sv
// Purpose: self-checking bench of the pin state retention controller
// Assumes: 200 MHz clock, sync active-low reset held for 10 cycles
// Notes:   drivers queue expected values; one monitor compares them

`timescale 1ns/1ps

module psr_pin_state_retention_bench;
  // ==========================================================================
  // settings and signals
  // ==========================================================================
  localparam logic [15:0] SW_M  = 16'h00ff;           // sw-standby wake pins
  localparam logic [15:0] DP_M  = 16'h0f0f;           // deep-standby wake pins
  localparam logic [15:0] USB_M = 16'h3000;           // usb data pins
  localparam logic [54:0] ALL   = {55{1'b1}};         // compare every field
  localparam logic [54:0] NRM   = {48'hffffffffffff, 7'h04}; // pass-through fields

  logic        clk = 1'b0;                            // clock
  logic        rst_b = 1'b0;                          // reset, low active
  logic [1:0]  powerMode = psr_pkg::MODE_RUN;         // requested mode
  logic        deepCancel = 1'b0;                     // cancel pulse
  logic [15:0] funcOut = '0, funcOe = '0, funcIe = '0; // functional pins
  logic [15:0] swWakeSel = '0, deepWakeSel = '0;      // wake selections
  logic [15:0] liveDrive = '0;                        // live outputs
  logic        jtagTdo = 1'b0;                        // debug tdo
  logic [7:0]  regAddr = '0;                          // register address
  logic [31:0] regWrData = '0;                        // write data
  logic        regWr = 1'b0, regRd = 1'b0;            // strobes
  logic [31:0] regRdData;                             // read data
  logic [15:0] padOut, padOe, padIe, pinLevel;        // pad outputs
  logic        modePullUp, tdoOut, tdoOe, ioRetentionHold; // single pads
  logic [2:0]  jtagPullUp;                            // jtag pull-ups
  logic [15:0] extVal = '0, extEn = '0;               // board drive
  int          clashCount;                            // board clashes
  logic [54:0] obsVec;                                // packed observation
  logic [109:0] padNotes[$];                          // mask and value notes
  logic [31:0] rdNotes[$];                            // expected read data
  logic [109:0] note;                                 // note being checked
  logic        padChk = 1'b0, rdDly = 1'b0;           // monitor triggers
  logic [15:0] lfsrQ = 16'h000d;                      // random source
  logic [54:0] frz;                                   // frozen pad image
  logic [15:0] rv;                                    // random value
  int          err_total = 0, n_compared = 0;         // counters

  assign obsVec = {padOut, padOe, padIe, modePullUp, jtagPullUp, tdoOut, tdoOe, ioRetentionHold};

  always #2.5 clk = ~clk;

  psr_pin_state_retention #(.NPINS(16), .SW_WAKE_M(SW_M), .DEEP_WK_M(DP_M), .USB_DAT_M(USB_M))
    psr_pin_state_retention_i (.clk(clk), .rst_b(rst_b), .powerMode(powerMode),
    .deepCancel(deepCancel), .funcOut(funcOut), .funcOe(funcOe), .funcIe(funcIe),
    .swWakeSel(swWakeSel), .deepWakeSel(deepWakeSel), .liveDrive(liveDrive),
    .jtagTdo(jtagTdo), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .padOut(padOut), .padOe(padOe), .padIe(padIe),
    .modePullUp(modePullUp), .jtagPullUp(jtagPullUp), .tdoOut(tdoOut), .tdoOe(tdoOe),
    .ioRetentionHold(ioRetentionHold));

  psr_board_model #(.NPINS(16)) psr_board_model_i (.clk(clk), .padOut(padOut),
    .padOe(padOe), .extVal(extVal), .extEn(extEn), .pinLevel(pinLevel),
    .clashCount(clashCount));

  // ==========================================================================
  // helpers
  // ==========================================================================
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic void rnd(output logic [15:0] v);
    lfsrQ = {lfsrQ[14:0], lfsrQ[15] ^ lfsrQ[13] ^ lfsrQ[12] ^ lfsrQ[10]};
    v = lfsrQ;
  endfunction

  function automatic logic [54:0] pk(input logic [15:0] o, e, i, input logic m,
                                     input logic [2:0] j, input logic t, te, h);
    return {o, e, i, m, j, t, te, h};
  endfunction

  task automatic check(input logic [54:0] seen, input logic [54:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // note pad expectations; the monitor compares at the next edge
  task automatic expect_pads(input logic [54:0] exp, input logic [54:0] msk);
    padNotes.push_back({msk, exp});
    padChk <= 1'b1;
    @(posedge clk);
    padChk <= 1'b0;
    @(posedge clk);
  endtask

  // one-cycle write strobe, then a free cycle
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask

  // one-cycle read strobe; data is compared in the following cycle
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    rdNotes.push_back(exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
  endtask

  // software standby then deep standby, leaving the frozen pad image
  task automatic run_standby(input logic hold, output logic [54:0] img);
    logic [15:0] o0, o1, e0, i0, w, lv, dw;
    rnd(o0); rnd(o1); rnd(e0); rnd(i0); rnd(w); rnd(lv); rnd(dw);
    funcOut <= o0;
    funcOe <= e0;
    funcIe <= i0;
    swWakeSel <= w;
    liveDrive <= lv;
    jtagTdo <= 1'b1;
    tick(1);
    powerMode <= psr_pkg::MODE_SW;
    tick(2);
    funcOut <= o1;                                    // only live pins follow
    jtagTdo <= 1'b0;
    deepCancel <= 1'b1;                               // ignored outside deep
    tick(1);
    deepCancel <= 1'b0;
    tick(2);
    img = pk((o0 & ~lv) | (o1 & lv), e0, (w & SW_M) | (i0 & USB_M), 1'b0, 3'h0, 1'b1, 1'b1, hold);
    expect_pads(img, ALL);
    reg_rd(psr_pkg::STAT_OFS, 32'h1);
    powerMode <= psr_pkg::MODE_DEEP;
    deepWakeSel <= dw;
    tick(2);
    powerMode <= psr_pkg::MODE_RUN;                   // ignored while deep
    funcOut <= ~o1;
    liveDrive <= ~lv;
    jtagTdo <= 1'b1;
    tick(3);
    img[22:7] = dw & DP_M;
    expect_pads(img, ALL);
    reg_rd(psr_pkg::STAT_OFS, 32'h2);
  endtask

  // ==========================================================================
  // monitor: oldest note against what the outputs show
  // ==========================================================================
  always @(posedge clk) begin
    if (padChk && padNotes.size() > 0) begin
      note = padNotes.pop_front();
      check(obsVec & note[109:55], note[54:0] & note[109:55]);
    end
    if (rdDly && rdNotes.size() > 0) begin
      check(55'(regRdData), 55'(rdNotes.pop_front()));
    end
    rdDly <= regRd;
  end

  // ==========================================================================
  // verdict and watchdog
  // ==========================================================================
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #(5ns * 4000);
    err_total++;
    report_and_stop();
  end

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    tick(8);
    expect_pads(pk('0, '0, '0, 1'b1, 3'h7, 1'b0, 1'b1, 1'b0), ALL);
    rst_b <= 1'b1;
    reg_rd(psr_pkg::CTRL_OFS, 32'h0);                 // hold resets clear
    rnd(rv);
    funcOut <= rv;
    funcOe <= ~rv;
    funcIe <= rv ^ 16'h00f0;
    jtagTdo <= 1'b1;
    tick(2);
    expect_pads(pk(rv, ~rv, rv ^ 16'h00f0, 1'b0, 3'h0, 1'b1, 1'b0, 1'b0), NRM);
    powerMode <= psr_pkg::MODE_SW;
    tick(2);
    powerMode <= 2'h3;                                // undefined code acts as run
    tick(2);
    reg_rd(psr_pkg::STAT_OFS, 32'h0);
    run_standby(1'b0, frz);
    deepCancel <= 1'b1;
    tick(1);
    deepCancel <= 1'b0;
    tick(2);
    expect_pads(pk('0, '0, '0, 1'b0, 3'h0, 1'b1, 1'b1, 1'b0), ALL);
    extVal <= 16'ha5c3;
    extEn <= 16'hffff;
    reg_rd(psr_pkg::STAT_OFS, 32'h3);
    check(55'(pinLevel), 55'(16'ha5c3));
    extEn <= 16'h0000;
    reg_wr(psr_pkg::CTRL_OFS, 32'h2);
    tick(1);
    reg_rd(psr_pkg::STAT_OFS, 32'h0);
    reg_wr(psr_pkg::CTRL_OFS, 32'h1);                 // software sets the hold bit
    reg_rd(psr_pkg::CTRL_OFS, 32'h1);
    run_standby(1'b1, frz);
    deepCancel <= 1'b1;
    tick(1);
    deepCancel <= 1'b0;
    rnd(rv);
    funcOut <= rv;
    jtagTdo <= 1'b0;
    tick(3);
    expect_pads(frz, ALL);
    reg_rd(psr_pkg::STAT_OFS, 32'h4);
    reg_wr(psr_pkg::CTRL_OFS, 32'h3);                 // release bit has no effect here
    reg_rd(psr_pkg::STAT_OFS, 32'h4);
    expect_pads(frz, ALL);
    reg_wr(psr_pkg::CTRL_OFS, 32'h0);                 // software clears hold
    tick(1);
    reg_rd(psr_pkg::STAT_OFS, 32'h0);
    funcOe <= 16'h0000;
    funcIe <= 16'h0000;
    tick(2);
    expect_pads(pk(rv, '0, '0, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0), NRM);
    reg_rd(8'h10, 32'h0);                             // unmapped reads zero
    check(55'(clashCount), 55'(0));
    report_and_stop();
  end
endmodule
